// ===== ovc_pkg.sv
// Constants of the clock-protect and regulator control block.
// Assumes a 32-bit AXI4-Lite register bus; each register is one aligned word.
package ovc_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_OSC  = 6'h1A;
  localparam logic [5:0] IDX_CONFIG_PROTECT = 6'h1B;
  localparam logic [5:0] IDX_TEST = 6'h1C;
  localparam logic [5:0] IDX_VREG = 6'h1D;
  localparam logic [5:0] IDX_OSC2 = 6'h1E;
  localparam logic [5:0] IDX_STAT = 6'h1F;
  // Field positions
  localparam int unsigned OSC_ENABLE_BIT = 7;
  localparam int unsigned OSC_RSVD_BIT   = 5;
  localparam int unsigned OSC2_MODE_BIT  = 0;
  localparam int unsigned OSC2_OSC_MONITOR_RESET_ENABLE_BIT  = 1;
  localparam int unsigned VREG_CORE_BIT  = 2;
  localparam int unsigned VREG_EXT_BIT   = 1;
  localparam int unsigned VREG_INT_BIT   = 0;
  localparam int unsigned STAT_LOCK_BIT  = 0;
  localparam int unsigned STAT_UP_BIT    = 1;
  localparam int unsigned STAT_PINS_BIT  = 2;
  localparam int unsigned STAT_VWR_BIT   = 3;
  localparam int unsigned STAT_SPEC_BIT  = 4;
  // Reset values
  localparam logic [7:0] OSC_RST  = 8'h00;
  localparam logic [7:0] OSC2_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [2:0] VREG_RST = 3'h5;
  localparam logic       CONFIG_PROTECT_RST = 1'b0;
  // Protection key
  localparam logic [7:0] CONFIG_PROTECT_KEY = 8'h26;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Decoded register selector
  typedef enum {
    OVC_SEL_NONE, OVC_SEL_OSC, OVC_SEL_CONFIG_PROTECT, OVC_SEL_TEST,
    OVC_SEL_VREG, OVC_SEL_OSC2, OVC_SEL_STAT
  } ovc_sel_t;
endpackage

// ===== ovc_top.sv
// Oscillator enable, configuration protect, factory test and regulator control registers.
// Assumes pll_select comes from logic on core_clk; pins from analog/pad side are synchronised.
// Operation
// - Oscillator writes need unprotected and PLL selected
// - Accepted oscillator write clears lock, stable flags
// - Enable low: oscillator off, reference from RC
// - Enable high: run, monitor, qualify, divided reference
// - Oscillation loss with monitor reset enabled raises reset
// - Enabling dedicates crystal pins until reset
// - Stable flag gates oscillator as clock source
// - Key value clears protect, else sets
// - Protect blocks clock configuration register writes
// - Test register writable only in special mode
// - Regulator register write-once in normal modes
// - Equal transistor selects block regulator write
// - Core domain enable bit drives core supply
// - External transistor select drives io loop
// - Internal transistor select drives io loop
// - Monitor reset enable frozen while oscillator on
module ovc_top
  import ovc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pll_select,
  input  wire logic              special_mode_pin,
  input  wire logic              osc_good_pin,
  input  wire logic              pll_lock_pin,
  output logic                   osc_power_en,
  output logic                   osc_monitor_en,
  output logic                   osc_qualify_en,
  output logic                   ref_from_osc,
  output logic                   crystal_pins_dedicated,
  output logic                   osc_clk_selectable,
  output logic                   osc_monitor_reset,
  output logic                   osc_full_swing,
  output logic                   config_protect,
  output logic                   core_domain_enable,
  output logic                   ext_transistor_select,
  output logic                   int_transistor_select,
  output logic [7:0]             factory_test_bits
);

  function automatic ovc_sel_t decode(input logic [ADDR_W-1:0] a);
    ovc_sel_t s;
    s = OVC_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[ADDR_W-1:2])
        IDX_OSC:  s = OVC_SEL_OSC;
        IDX_CONFIG_PROTECT: s = OVC_SEL_CONFIG_PROTECT;
        IDX_TEST: s = OVC_SEL_TEST;
        IDX_VREG: s = OVC_SEL_VREG;
        IDX_OSC2: s = OVC_SEL_OSC2;
        IDX_STAT: s = OVC_SEL_STAT;
        default:  s = OVC_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Pad-side inputs: two flops each before anything looks at them
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= {special_mode_pin, osc_good_pin, pll_lock_pin};
      sync_r <= meta_r;
    end
  end
  logic special_s;
  logic good_s;
  logic lock_s;
  assign special_s = sync_r[2];
  assign good_s    = sync_r[1];
  assign lock_s    = sync_r[0];

  logic good_d_r;
  logic lock_d_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      good_d_r <= 1'b0;
      lock_d_r <= 1'b0;
    end else begin
      good_d_r <= good_s;
      lock_d_r <= lock_s;
    end
  end

  // Write channel: address and data held independently, taken in either order
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_full_r;
  logic [7:0]        w_data_r;
  logic              w_en_r;
  logic              w_full_r;
  logic              wr_fire;
  ovc_sel_t          wr_sel;
  assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_sel  = decode(aw_addr_r);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_full_r     <= 1'b0;
      aw_addr_r     <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      w_full_r     <= 1'b0;
      w_data_r     <= 8'h00;
      w_en_r       <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r     <= 1'b1;
      w_data_r     <= s_axi_wdata[7:0];
      w_en_r       <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == OVC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Per-register write acceptance; a refused write touches nothing
  logic wr_any;
  logic osc_wr_ok;
  logic osc2_wr_ok;
  logic config_protect_wr;
  logic test_wr_ok;
  logic vreg_wr_ok;
  logic vreg_written_r;
  assign wr_any     = wr_fire && w_en_r;
  assign osc_wr_ok  = wr_any && wr_sel == OVC_SEL_OSC && !config_protect
                      && pll_select;
  assign osc2_wr_ok = wr_any && wr_sel == OVC_SEL_OSC2 && !config_protect
                      && pll_select;
  assign config_protect_wr    = wr_any && wr_sel == OVC_SEL_CONFIG_PROTECT;
  assign test_wr_ok = wr_any && wr_sel == OVC_SEL_TEST && special_s;
  assign vreg_wr_ok = wr_any && wr_sel == OVC_SEL_VREG
                      && (special_s || !vreg_written_r)
                      && (w_data_r[VREG_EXT_BIT] != w_data_r[VREG_INT_BIT]);

  // Key register: any write other than the key re-arms protection
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      config_protect <= CONFIG_PROTECT_RST;
    end else if (config_protect_wr) begin
      config_protect <= (w_data_r != CONFIG_PROTECT_KEY);
    end
  end

  logic [7:0] osc_ctrl_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc_ctrl_r <= OSC_RST;
    end else if (osc_wr_ok) begin
      osc_ctrl_r <= w_data_r;
    end
  end

  logic osc_en;
  assign osc_en = osc_ctrl_r[OSC_ENABLE_BIT];

  // Oscillator mode and monitor reset enable cannot change while it runs
  logic [7:0] osc2_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc2_r <= OSC2_RST;
    end else if (osc2_wr_ok && !osc_en) begin
      osc2_r <= {6'h00, w_data_r[OSC2_OSC_MONITOR_RESET_ENABLE_BIT], w_data_r[OSC2_MODE_BIT]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      factory_test_bits <= TEST_RST;
    end else if (test_wr_ok) begin
      factory_test_bits <= w_data_r;
    end
  end

  logic [2:0] vreg_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      vreg_r         <= VREG_RST;
      vreg_written_r <= 1'b0;
    end else if (vreg_wr_ok) begin
      vreg_r         <= w_data_r[2:0];
      vreg_written_r <= 1'b1;
    end
  end

  // Status flags: a fresh rising event in the clearing cycle wins
  logic pll_locked_r;
  logic osc_stable_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pll_locked_r <= 1'b0;
      osc_stable_r <= 1'b0;
    end else begin
      pll_locked_r <= (lock_s && !lock_d_r)
                      || (pll_locked_r && lock_s && !osc_wr_ok);
      osc_stable_r <= (osc_en && good_s && !good_d_r)
                      || (osc_stable_r && osc_en && good_s && !osc_wr_ok);
    end
  end

  // Oscillator side effects; the pins stay claimed until reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc_power_en           <= 1'b0;
      osc_monitor_en         <= 1'b0;
      osc_qualify_en         <= 1'b0;
      ref_from_osc           <= 1'b0;
      crystal_pins_dedicated <= 1'b0;
      osc_clk_selectable     <= 1'b0;
      osc_monitor_reset      <= 1'b0;
      osc_full_swing         <= 1'b0;
    end else begin
      osc_power_en           <= osc_en;
      osc_monitor_en         <= osc_en;
      osc_qualify_en         <= osc_en;
      ref_from_osc           <= osc_en;
      crystal_pins_dedicated <= crystal_pins_dedicated || osc_en;
      osc_clk_selectable     <= osc_stable_r;
      osc_monitor_reset      <= osc_en && osc2_r[OSC2_OSC_MONITOR_RESET_ENABLE_BIT]
                                && good_d_r && !good_s;
      osc_full_swing         <= osc2_r[OSC2_MODE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      core_domain_enable    <= VREG_RST[VREG_CORE_BIT];
      ext_transistor_select <= VREG_RST[VREG_EXT_BIT];
      int_transistor_select <= VREG_RST[VREG_INT_BIT];
    end else begin
      core_domain_enable    <= vreg_r[VREG_CORE_BIT];
      ext_transistor_select <= vreg_r[VREG_EXT_BIT];
      int_transistor_select <= vreg_r[VREG_INT_BIT];
    end
  end

  // Read channel: one word per request, answered the cycle after it is taken
  logic [7:0] rd_byte;
  ovc_sel_t   rd_sel;
  assign rd_sel = decode(s_axi_araddr);
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_sel)
      OVC_SEL_OSC:  rd_byte = osc_ctrl_r;
      OVC_SEL_CONFIG_PROTECT: rd_byte = {7'h00, config_protect};
      OVC_SEL_TEST: rd_byte = factory_test_bits;
      OVC_SEL_VREG: rd_byte = {5'h00, vreg_r};
      OVC_SEL_OSC2: rd_byte = osc2_r;
      OVC_SEL_STAT: rd_byte = {3'h0, special_s, vreg_written_r, crystal_pins_dedicated,
                               osc_stable_r, pll_locked_r};
      OVC_SEL_NONE: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= (rd_sel == OVC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_osc_wr_on;
    osc_wr_ok && w_data_r[OSC_ENABLE_BIT];
  endsequence
  sequence s_side_on;
    osc_en ##1 (osc_power_en && ref_from_osc && osc_monitor_en && osc_qualify_en);
  endsequence

  a_osc_wr_gate: assert property (
    (wr_any && wr_sel == OVC_SEL_OSC && (config_protect || !pll_select))
    |=> $stable(osc_ctrl_r))
    else $error("oscillator register changed while locked");
  a_osc_flag_clear: assert property (
    (osc_wr_ok && lock_d_r && (good_d_r || !good_s)) |=> !pll_locked_r && !osc_stable_r)
    else $error("status flags survived oscillator write");
  a_osc_enable_path: assert property (
    s_osc_wr_on |=> s_side_on)
    else $error("oscillator enable side effects missing");
  a_osc_off_rc: assert property (
    (!osc_en && !osc_wr_ok) [*2] |-> !ref_from_osc && !osc_power_en)
    else $error("reference not on rc clock while disabled");
  a_pins_stay_claimed: assert property (
    crystal_pins_dedicated |=> crystal_pins_dedicated)
    else $error("crystal pins released before reset");
  a_config_protect_key_value: assert property (
    config_protect_wr |=> config_protect == ($past(w_data_r) != CONFIG_PROTECT_KEY))
    else $error("protect bit wrong after key write");
  a_test_mode_gate: assert property (
    (wr_any && wr_sel == OVC_SEL_TEST && !special_s) |=> $stable(factory_test_bits))
    else $error("test register written in normal mode");
  a_vreg_write_once: assert property (
    (vreg_written_r && !special_s && wr_sel == OVC_SEL_VREG && wr_any) |=> $stable(vreg_r))
    else $error("regulator register written twice");
  a_vreg_combo_block: assert property (
    (wr_any && wr_sel == OVC_SEL_VREG && w_data_r[VREG_EXT_BIT] == w_data_r[VREG_INT_BIT])
    |=> $stable(vreg_r) && $stable(vreg_written_r))
    else $error("illegal transistor select accepted");
  a_mon_reset_cause: assert property (
    osc_monitor_reset |-> $past(osc_en) && $past(osc2_r[OSC2_OSC_MONITOR_RESET_ENABLE_BIT]) && !$past(good_s))
    else $error("monitor reset without cause");
  a_osc_monitor_reset_enable_frozen: assert property (
    osc_en && !osc_wr_ok |=> $stable(osc2_r))
    else $error("monitor enable changed while oscillator on");
  a_stable_gates_sel: assert property (
    osc_clk_selectable |-> $past(osc_stable_r) && $past(osc_en, 2))
    else $error("oscillator selectable before stable");
  a_write_answer: assert property (
    (wr_fire || (s_axi_bvalid && !s_axi_bready)) |=> s_axi_bvalid)
    else $error("write response not held");

endmodule

// ===== osc_protect_vreg_control_tb.sv
// Self-checking bench for the oscillator, protect, test and regulator registers.
// Drives the AXI4-Lite slave and the analog status pins itself; no partner model.
module osc_protect_vreg_control_tb import ovc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_OSC  = {IDX_OSC, 2'b00};
  localparam logic [7:0] A_CONFIG_PROTECT = {IDX_CONFIG_PROTECT, 2'b00};
  localparam logic [7:0] A_TEST = {IDX_TEST, 2'b00};
  localparam logic [7:0] A_VREG = {IDX_VREG, 2'b00};
  localparam logic [7:0] A_OSC2 = {IDX_OSC2, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
  logic core_clk = 1'b0, sys_rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pll_select = 1, special_mode_pin = 0, osc_good_pin = 0, pll_lock_pin = 0;
  logic osc_power_en, osc_monitor_en, osc_qualify_en, ref_from_osc, crystal_pins_dedicated;
  logic osc_clk_selectable, osc_monitor_reset, osc_full_swing, config_protect;
  logic core_domain_enable, ext_transistor_select, int_transistor_select;
  logic [7:0] factory_test_bits;
  int n_errors = 0, n_compared = 0, n_mr = 0;

  ovc_top ovc_top_inst (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pll_select, .special_mode_pin, .osc_good_pin, .pll_lock_pin,
    .osc_power_en, .osc_monitor_en, .osc_qualify_en, .ref_from_osc, .crystal_pins_dedicated,
    .osc_clk_selectable, .osc_monitor_reset, .osc_full_swing, .config_protect,
    .core_domain_enable, .ext_transistor_select, .int_transistor_select, .factory_test_bits);

  always #5 core_clk = ~core_clk;
  // Counts monitor reset pulses; sampled at the edge so the registered value is settled
  always @(posedge core_clk) if (osc_monitor_reset === 1'b1) n_mr <= n_mr + 1;

  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Ready is registered, so its value at the falling edge is what the next rising edge sees
  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic a, w, b, got;
    got = 1'b0;
    resp = 2'h3;
    @(posedge core_clk);
    s_axi_awaddr  <= addr;
    s_axi_wdata   <= {24'h0, data};
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge core_clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = (s_axi_bvalid === 1'b1);
      if (b) resp = s_axi_bresp;
      @(posedge core_clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      got = b;
    end
  endtask
  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic a, r, got;
    got = 1'b0;
    data = '1;
    resp = 2'h3;
    @(posedge core_clk);
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge core_clk);
      a = s_axi_arvalid && s_axi_arready;
      r = (s_axi_rvalid === 1'b1);
      if (r) data = s_axi_rdata;
      if (r) resp = s_axi_rresp;
      @(posedge core_clk);
      if (a) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
      got = r;
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [1:0] r;
    axi_write(addr, data, 4'h1, r);
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(addr, d, r);
    chk_data(d, {24'h0, exp});
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask
  task automatic pins(input logic good, input logic lock);
    @(posedge core_clk);
    osc_good_pin <= good;
    pll_lock_pin <= lock;
    // Two sync flops plus the flag register
    repeat (6) @(posedge core_clk);
  endtask

  task automatic t_reset_vals();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(A_OSC, OSC_RST);
    rd_chk(A_TEST, TEST_RST);
    rd_chk(A_VREG, {5'h0, VREG_RST});
    @(negedge core_clk);
    chk_flag(config_protect, CONFIG_PROTECT_RST);
    chk_flag(core_domain_enable, 1'b1);
    chk_flag(ext_transistor_select, 1'b0);
    chk_flag(int_transistor_select, 1'b1);
    chk_flag(osc_power_en, 1'b0);
    chk_flag(ref_from_osc, 1'b0);
    axi_read(8'h40, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_data(d, 32'h0);
    axi_write(A_OSC + 8'h01, 8'h80, 4'h1, r);
    chk_resp(r, RESP_SLVERR);
    axi_write(A_VREG, 8'h02, 4'h0, r);
    rd_chk(A_VREG, {5'h0, VREG_RST});
  endtask

  task automatic t_protect();
    @(posedge core_clk);
    pll_select <= 1'b0;
    wr(A_OSC, 8'h80);
    rd_chk(A_OSC, 8'h00);
    @(posedge core_clk);
    pll_select <= 1'b1;
    wr(A_CONFIG_PROTECT, 8'h00);
    @(negedge core_clk);
    chk_flag(config_protect, 1'b1);
    wr(A_OSC, 8'h80);
    rd_chk(A_OSC, 8'h00);
    wr(A_OSC2, 8'h02);
    rd_chk(A_OSC2, 8'h00);
    wr(A_CONFIG_PROTECT, CONFIG_PROTECT_KEY);
    @(negedge core_clk);
    chk_flag(config_protect, 1'b0);
    wr(A_CONFIG_PROTECT, 8'h27);
    @(negedge core_clk);
    chk_flag(config_protect, 1'b1);
    wr(A_CONFIG_PROTECT, CONFIG_PROTECT_KEY);
  endtask

  task automatic t_osc();
    logic [31:0] d;
    logic [1:0] r;
    wr(A_OSC2, 8'h03);
    rd_chk(A_OSC2, 8'h03);
    @(negedge core_clk);
    chk_flag(osc_full_swing, 1'b1);
    wr(A_OSC, 8'h80);
    @(negedge core_clk);
    chk_data({osc_power_en, osc_monitor_en, osc_qualify_en, ref_from_osc}, 32'hF);
    chk_flag(crystal_pins_dedicated, 1'b1);
    chk_flag(osc_clk_selectable, 1'b0);
    pins(1'b1, 1'b1);
    axi_read(A_STAT, d, r);
    chk_data(d[1:0], 32'h3);
    chk_flag(osc_clk_selectable, 1'b1);
    wr(A_OSC2, 8'h00);
    rd_chk(A_OSC2, 8'h03);
    chk_flag(osc_full_swing, 1'b1);
    wr(A_CONFIG_PROTECT, 8'h00);
    wr(A_OSC, 8'h00);
    axi_read(A_STAT, d, r);
    chk_data(d[1:0], 32'h3);
    chk_flag(osc_power_en, 1'b1);
    wr(A_CONFIG_PROTECT, CONFIG_PROTECT_KEY);
    wr(A_OSC, 8'h80);
    axi_read(A_STAT, d, r);
    chk_data(d[1:0], 32'h0);
    n_mr = 0;
    pins(1'b0, 1'b1);
    chk_data(n_mr, 32'd1);
    pins(1'b1, 1'b1);
    wr(A_OSC, 8'h00);
    @(negedge core_clk);
    chk_data({osc_power_en, ref_from_osc}, 32'h0);
    chk_flag(crystal_pins_dedicated, 1'b1);
    n_mr = 0;
    pins(1'b0, 1'b0);
    chk_data(n_mr, 32'd0);
  endtask

  task automatic t_vreg_normal();
    wr(A_VREG, 8'h03);
    rd_chk(A_VREG, 8'h05);
    wr(A_VREG, 8'h04);
    rd_chk(A_VREG, 8'h05);
    wr(A_VREG, 8'h02);
    rd_chk(A_VREG, 8'h02);
    @(negedge core_clk);
    chk_flag(core_domain_enable, 1'b0);
    chk_flag(ext_transistor_select, 1'b1);
    chk_flag(int_transistor_select, 1'b0);
    wr(A_VREG, 8'h05);
    rd_chk(A_VREG, 8'h02);
    wr(A_TEST, 8'h5A);
    rd_chk(A_TEST, 8'h00);
  endtask

  task automatic t_special();
    @(posedge core_clk);
    special_mode_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(A_TEST, 8'h5A);
    rd_chk(A_TEST, 8'h5A);
    chk_data(factory_test_bits, 32'h5A);
    wr(A_VREG, 8'h05);
    rd_chk(A_VREG, 8'h05);
    wr(A_VREG, 8'h06);
    rd_chk(A_VREG, 8'h06);
    wr(A_VREG, 8'h07);
    rd_chk(A_VREG, 8'h06);
    @(posedge core_clk);
    special_mode_pin <= 1'b0;
    do_reset();
    @(negedge core_clk);
    chk_flag(crystal_pins_dedicated, 1'b0);
    rd_chk(A_VREG, {5'h0, VREG_RST});
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_protect();
    t_osc();
    t_vreg_normal();
    t_special();
    report_and_stop();
  end
  // The sequence needs about 250 cycles; a hang is cut off well after that
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
